// File: src/sas_map.svh
// Functional notes
// - starting a conversion holds every input together
// - write fall samples, write rise loads configuration
// - hard-wired mode converts on one write
// - later writes reconvert selected channels, no reconfiguration
// - each read returns location, then advances address
// - multi-channel write fall clears result address
// - inhibited write sets result address for read
// - address bits pick channel or result location
// - power-down bit idles converter, keeps configuration
// - inhibit bit blocks conversion, still loads configuration
// - range bit picks unipolar or bipolar channel
// - pairing bit picks single-ended or differential channel
// - single-channel bit limits conversion to addressed channel
// - channel selection applies to same write
// - range and pairing apply one write later
// - shared data lines driven only during reads
// - mode and supply straps pick fixed configurations
// - single-ended: address picks positive, ground negative
// - differential pairs 0/1..6/7, bit 0 picks positive
// - hard-wired mode ignores data lines on writes
// - busy low throughout conversion, high once stored
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH
`define SAS_NCH 8
`define SAS_RES_BITS 8
`define SAS_ADDR_LSB 0
`define SAS_ADDR_MSB 2
`define SAS_PD_BIT 3
`define SAS_INH_BIT 4
`define SAS_BIP_BIT 5
`define SAS_PAIR_INPUT_SELECT_BIT 6
`define SAS_ALL_BIT 7
`define SAS_CFG_RESET 8'h00
`define SAS_HW_SE_MASK 8'hFF
`define SAS_HW_PAIR_INPUT_SELECT_MASK 8'h55
`define SAS_SAR_FIRST 8'h80
`endif

// File: src/sas_pkg.sv
`include "sas_map.svh"
package sas_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_SCAN,
    ST_CONV,
    ST_STORE
  } sas_state_t;
  typedef logic [`SAS_RES_BITS-1:0] sas_code_t;
endpackage : sas_pkg

// File: src/sas_sar_if.sv
`timescale 1ns/1ps
`include "sas_map.svh"
interface sas_sar_if;
  logic start;
  logic step;
  logic comp;
  logic done;
  logic [`SAS_RES_BITS-1:0] code;
  logic [`SAS_RES_BITS-1:0] dac;
  modport ctl (output start, output step, output comp,
    input done, input code, input dac);
  modport eng (input start, input step, input comp,
    output done, output code, output dac);
endinterface : sas_sar_if

// File: src/sas_sync.sv
`timescale 1ns/1ps
module sas_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0 // idle level of each pin
)(
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // sync reset
  input wire logic [W-1:0] din, // asynchronous inputs
  output logic [W-1:0] dout // synchronised copy
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : sas_sync

// File: src/sas_sar.sv
`timescale 1ns/1ps
`include "sas_map.svh"
module sas_sar
  import sas_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // sync reset
  sas_sar_if.eng sar // engine side
);
  logic run_q;
  logic done_q;
  sas_code_t trial_q;
  sas_code_t dac_q;
  sas_code_t code_q;

  // one decision per converter clock step after the first, msb first
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      run_q <= 1'b0;
      done_q <= 1'b0;
      trial_q <= '0;
      dac_q <= '0;
      code_q <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      if (sar.start)
      begin
        run_q <= 1'b1;
        trial_q <= '0;
        dac_q <= `SAS_SAR_FIRST;
      end
      else if (run_q && sar.step && trial_q == '0)
        trial_q <= `SAS_SAR_FIRST; // first step only lets comparator settle
      else if (run_q && sar.step)
      begin
        trial_q <= trial_q >> 1;
        if (trial_q[0])
        begin
          run_q <= 1'b0;
          done_q <= 1'b1;
          code_q <= sar.comp ? dac_q : (dac_q & ~trial_q);
        end
        else
          dac_q <= (sar.comp ? dac_q : (dac_q & ~trial_q))
            | (trial_q >> 1);
      end
    end
  end

  assign sar.done = done_q;
  assign sar.code = code_q;
  assign sar.dac = dac_q;
endmodule : sas_sar

// File: src/sas_top.sv
`timescale 1ns/1ps
`include "sas_map.svh"
module sas_top
  import sas_pkg::*;
(
  input wire logic sys_clk, // 250 MHz system clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic cs_n, // chip select pin
  input wire logic wr_n, // write strobe pin
  input wire logic rd_n, // read strobe pin
  input wire logic conv_clk, // external converter clock pin
  input wire logic [7:0] data_in, // shared data lines, input side
  output logic [7:0] data_out, // shared data lines, output side
  output logic data_oe_n, // low while data lines driven
  input wire logic mode_float, // strap: mode pin unconnected
  input wire logic mode_level, // strap: mode pin level
  input wire logic vss_neg, // strap: negative supply present
  input wire logic comp_above, // comparator: input above dac
  output logic busy_n, // low while converting
  output logic hold_all, // all track/holds in hold
  output logic [2:0] mux_pos, // positive analog_input channel
  output logic [2:0] mux_neg, // negative channel when paired
  output logic mux_neg_gnd, // negative input is analog_ground
  output logic range_bipolar, // signed range in use
  output logic [7:0] dac_code, // trial code to dac
  output logic power_down // low-power request
);
  localparam int NCH = `SAS_NCH;

  logic [15:0] pins_raw;
  logic [15:0] pins_s;
  logic cs_n_s;
  logic wr_n_s;
  logic rd_n_s;
  logic clk_s;
  logic comp_s;
  logic float_s;
  logic level_s;
  logic vneg_s;
  logic [7:0] din_s;

  assign pins_raw = {data_in, vss_neg, mode_level, mode_float,
    comp_above, conv_clk, rd_n, wr_n, cs_n};

  // sync flops reset to idle pin levels, so no false strobe edge
  sas_sync #(.W(16), .INIT(16'h0027)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din(pins_raw),
    .dout(pins_s)
  );

  assign cs_n_s = pins_s[0];
  assign wr_n_s = pins_s[1];
  assign rd_n_s = pins_s[2];
  assign clk_s = pins_s[3];
  assign comp_s = pins_s[4];
  assign float_s = pins_s[5];
  assign level_s = pins_s[6];
  assign vneg_s = pins_s[7];
  assign din_s = pins_s[15:8];

  // strobe edges, gated by chip select
  logic wr_act;
  logic rd_act;
  logic wr_act_q;
  logic rd_act_q;
  logic clk_q;
  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic step;

  assign wr_act = ~cs_n_s & ~wr_n_s;
  assign rd_act = ~cs_n_s & ~rd_n_s;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      clk_q <= 1'b0;
    end
    else
    begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      clk_q <= clk_s;
    end
  end

  assign wr_fall = wr_act & ~wr_act_q;
  assign wr_rise = ~wr_act & wr_act_q;
  assign rd_fall = rd_act & ~rd_act_q;
  assign rd_rise = ~rd_act & rd_act_q;
  assign step = clk_s & ~clk_q;

  // configuration fields of the presented write
  logic hardwired;
  logic reg_wr;
  logic [2:0] wr_addr;
  logic wr_inh;
  logic wr_pd;
  logic wr_single;

  assign hardwired = ~float_s;
  assign reg_wr = wr_rise & ~hardwired;
  assign wr_addr = din_s[`SAS_ADDR_MSB:`SAS_ADDR_LSB];
  assign wr_inh = din_s[`SAS_INH_BIT];
  assign wr_pd = din_s[`SAS_PD_BIT];
  assign wr_single = din_s[`SAS_ALL_BIT];

  // mux_configuration storage
  logic [NCH-1:0] sel_q;
  logic [NCH-1:0] pend_bip_q;
  logic [NCH-1:0] pend_pair_input_select_q;
  logic [NCH-1:0] eff_bip_q;
  logic [NCH-1:0] eff_pair_input_select_q;
  logic single_q;
  logic [2:0] single_ch_q;
  logic pd_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sel_q <= `SAS_CFG_RESET;
      pend_bip_q <= `SAS_CFG_RESET;
      pend_pair_input_select_q <= `SAS_CFG_RESET;
      eff_bip_q <= `SAS_CFG_RESET;
      eff_pair_input_select_q <= `SAS_CFG_RESET;
      single_q <= 1'b0;
      single_ch_q <= 3'h0;
      pd_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      eff_bip_q <= pend_bip_q;
      eff_pair_input_select_q <= pend_pair_input_select_q;
      pend_bip_q[wr_addr] <= din_s[`SAS_BIP_BIT];
      pend_pair_input_select_q[wr_addr] <= din_s[`SAS_PAIR_INPUT_SELECT_BIT];
      pd_q <= wr_pd;
      single_q <= wr_single;
      single_ch_q <= wr_addr;
      if (!wr_single)
      begin
        sel_q[wr_addr] <= 1'b1;
        if (din_s[`SAS_PAIR_INPUT_SELECT_BIT])
          sel_q[wr_addr ^ 3'h1] <= 1'b0;
      end
    end
  end

  // conversion sequencer
  sas_state_t state_q;
  logic [NCH-1:0] run_mask_q;
  logic [2:0] ch_q;
  logic start_now;
  logic multi_fall;
  sas_sar_if sar_if ();

  assign start_now = wr_rise & (state_q == ST_IDLE)
    & (hardwired | (~wr_inh & ~wr_pd));
  assign multi_fall = wr_fall & (hardwired | ~single_q);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      run_mask_q <= '0;
      ch_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (start_now)
            state_q <= ST_LOAD;
        ST_LOAD:
        begin
          ch_q <= 3'h0;
          state_q <= ST_SCAN;
          if (hardwired)
            run_mask_q <= level_s ? `SAS_HW_PAIR_INPUT_SELECT_MASK
              : `SAS_HW_SE_MASK;
          else if (single_q)
            run_mask_q <= NCH'(1) << single_ch_q;
          else
            run_mask_q <= sel_q;
        end
        ST_SCAN:
          if (run_mask_q[ch_q])
            state_q <= ST_CONV;
          else if (ch_q == 3'(NCH - 1))
            state_q <= ST_IDLE;
          else
            ch_q <= ch_q + 3'h1;
        ST_CONV:
          if (sar_if.done)
            state_q <= ST_STORE;
        ST_STORE:
        begin
          run_mask_q[ch_q] <= 1'b0;
          state_q <= ST_SCAN;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  assign busy_n = (state_q == ST_IDLE);

  // all track/holds close together on the write fall
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      hold_all <= 1'b0;
    else if (wr_fall)
      hold_all <= 1'b1;
    else if (wr_rise && !start_now && state_q == ST_IDLE)
      hold_all <= 1'b0;
    else if (state_q == ST_SCAN && !run_mask_q[ch_q]
      && ch_q == 3'(NCH - 1))
      hold_all <= 1'b0;
  end

  // analog mux steering for the channel in conversion
  logic ch_pair_input_select;
  logic ch_bip;

  assign ch_pair_input_select = hardwired ? level_s : eff_pair_input_select_q[ch_q];
  assign ch_bip = hardwired ? vneg_s : eff_bip_q[ch_q];

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mux_pos <= 3'h0;
      mux_neg <= 3'h0;
      mux_neg_gnd <= 1'b1;
      range_bipolar <= 1'b0;
    end
    else if (state_q == ST_SCAN && run_mask_q[ch_q])
    begin
      mux_pos <= ch_q;
      mux_neg <= ch_q ^ 3'h1;
      mux_neg_gnd <= ~ch_pair_input_select;
      range_bipolar <= ch_bip;
    end
  end

  assign sar_if.start = (state_q == ST_SCAN) & run_mask_q[ch_q];
  assign sar_if.step = step;
  assign sar_if.comp = comp_s;
  assign dac_code = sar_if.dac;

  sas_sar u_sar (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sar(sar_if.eng)
  );

  // result RAM and its walking address
  sas_code_t ram_q [NCH];
  logic [2:0] ptr_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NCH; i++)
        ram_q[i] <= '0;
    end
    else if (state_q == ST_CONV && sar_if.done)
      ram_q[ch_q] <= sar_if.code;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      ptr_q <= 3'h0;
    else if (multi_fall)
      ptr_q <= 3'h0;
    else if (reg_wr && (wr_inh || wr_single))
      ptr_q <= wr_addr;
    else if (rd_rise)
      ptr_q <= ptr_q + 3'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      data_out <= 8'h00;
    else if (rd_fall)
      data_out <= ram_q[ptr_q];
  end

  assign data_oe_n = ~rd_act;
  assign power_down = ~hardwired & pd_q;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_conv_begin;
    start_now ##1 (state_q == ST_LOAD);
  endsequence

  property p_busy_start;
    s_conv_begin |=> !busy_n [*2];
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy not low after conversion start");
  property p_hold_fall;
    wr_fall |=> hold_all;
  endproperty
  a_hold_fall: assert property (p_hold_fall)
    else $error("inputs not held after write fall");
  property p_ptr_clear;
    multi_fall |=> ptr_q == 3'h0;
  endproperty
  a_ptr_clear: assert property (p_ptr_clear)
    else $error("result address not cleared");
  property p_rd_incr;
    rd_rise && !wr_act && !wr_act_q |=> ptr_q == $past(ptr_q) + 3'h1;
  endproperty
  a_rd_incr: assert property (p_rd_incr)
    else $error("result address did not advance");
  property p_inh_block;
    wr_rise && !hardwired && wr_inh && busy_n |=> busy_n [*3];
  endproperty
  a_inh_block: assert property (p_inh_block)
    else $error("inhibited write started a conversion");
  property p_inh_addr;
    reg_wr && wr_inh |=> ptr_q == $past(wr_addr);
  endproperty
  a_inh_addr: assert property (p_inh_addr)
    else $error("inhibited write did not set address");
  property p_latency;
    reg_wr |=> eff_pair_input_select_q == $past(pend_pair_input_select_q)
      && eff_bip_q == $past(pend_bip_q);
  endproperty
  a_latency: assert property (p_latency)
    else $error("range or pairing took effect early");
  property p_hw_ignore;
    wr_rise && hardwired |=> sel_q == $past(sel_q)
      && pd_q == $past(pd_q);
  endproperty
  a_hw_ignore: assert property (p_hw_ignore)
    else $error("hard-wired write changed configuration");

  property p_drive_read;
    (cs_n || rd_n) [*3] |-> data_oe_n;
  endproperty
  a_drive_read: assert property (p_drive_read)
    else $error("data lines driven outside a read");

  property p_store_order;
    (state_q == ST_STORE) |=> (state_q == ST_SCAN)
      && !run_mask_q[ch_q];
  endproperty
  a_store_order: assert property (p_store_order)
    else $error("stored channel still pending");
endmodule : sas_top

// File: verification/sas_host_model.sv
`timescale 1ns/1ps
module sas_host_model (
  input wire logic sys_clk, // system clock
  output logic cs_n, // chip select
  output logic wr_n, // write strobe
  output logic rd_n, // read strobe
  output logic [7:0] drv, // value put on lines
  output logic drv_en, // host drives lines
  input wire logic [7:0] lines // resolved lines
);
  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    drv = 8'h00;
    drv_en = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // strobe-low phases well above the three-cycle minimum
  task automatic wr(input logic [7:0] v, input logic sel);
    cs_n = ~sel;
    drv = v;
    drv_en = 1'b1;
    cyc(2);
    wr_n = 1'b0;
    cyc(6);
    wr_n = 1'b1;
    cyc(3);
    drv_en = 1'b0;
    cs_n = 1'b1;
    cyc(6);
  endtask : wr
  task automatic rd(output logic [7:0] v);
    cs_n = 1'b0;
    cyc(2);
    rd_n = 1'b0;
    cyc(6);
    v = lines;
    rd_n = 1'b1;
    cyc(1);
    cs_n = 1'b1;
    cyc(6);
  endtask : rd
endmodule : sas_host_model

// File: verification/simultaneous_adc_sequencer_bench.sv
`timescale 1ns/1ps
module simultaneous_adc_sequencer_bench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cs_n, wr_n, rd_n, data_oe_n, busy_n, hold_all;
  logic conv_clk = 1'b0;
  logic mode_float = 1'b1;
  logic mode_level = 1'b0;
  logic vss_neg = 1'b0;
  logic comp_above = 1'b0;
  logic [7:0] data_in, data_out, dac_code, drv;
  logic [2:0] mux_pos, mux_neg;
  logic mux_neg_gnd, range_bipolar, power_down, drv_en, b, g;
  logic hold_q = 1'b0;
  logic [7:0] last_q = 8'h00;
  logic [7:0] analog_input [8];
  logic [7:0] held [8];
  logic [7:0] exp_ram [8];
  logic sel_m [8];
  int ptr_m = 0;
  logic single_m = 1'b0;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'h153E;
  sas_top u_sas_top (.sys_clk, .sys_rst, .cs_n, .wr_n, .rd_n, .conv_clk,
    .data_in, .data_out, .data_oe_n, .mode_float, .mode_level, .vss_neg,
    .comp_above, .busy_n, .hold_all, .mux_pos, .mux_neg, .mux_neg_gnd,
    .range_bipolar, .dac_code, .power_down);
  sas_host_model u_sas_host_model (.sys_clk, .cs_n, .wr_n, .rd_n, .drv,
    .drv_en, .lines(data_in));
  always #2 sys_clk = ~sys_clk;
  // released lines show the inverse of their last value
  assign data_in = (data_oe_n === 1'b0) ? data_out : drv_en ? drv : ~last_q;
  always @(negedge sys_clk)
  begin
    hold_q <= hold_all;
    if (hold_all && !hold_q)
      held <= analog_input;
    if (data_oe_n === 1'b0)
      last_q <= data_out;
    else if (drv_en)
      last_q <= drv;
    // converter clock moves with the other inputs, 80 ns period
    if (cycles % 10 == 0)
      conv_clk <= ~conv_clk;
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      give_verdict();
    end
  end
  // analog world moves on once the strobe rises
  always @(posedge wr_n)
    for (int i = 0; i < 8; i++)
      analog_input[i] = 8'($random(seed));
  always @(negedge sys_clk)
    comp_above <= {held[mux_pos], 1'b1} > {dac_code, 1'b0};
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] v, output logic signed_range_select, output logic ng);
    int a;
    int n;
    logic go;
    a = v[2:0];
    go = !mode_float || (v[4:3] == 2'b00);
    if (mode_float && !v[7])
    begin
      sel_m[a] = 1'b1;
      if (v[6])
        sel_m[a ^ 1] = 1'b0;
    end
    if (mode_float && (v[7] || v[4]))
      ptr_m = a;
    else if (!mode_float || !single_m)
      ptr_m = 0;
    if (mode_float)
      single_m = v[7];
    for (int i = 0; i < 8; i++)
      if (go && (mode_float ? (v[7] ? i == a : sel_m[i] === 1'b1)
          : (!mode_level || i % 2 == 0)))
        exp_ram[i] = analog_input[i];
    u_sas_host_model.wr(v, 1'b1);
    n = 0;
    while (busy_n !== 1'b0 && n < 30)
    begin
      @(negedge sys_clk);
      n++;
    end
    signed_range_select = range_bipolar;
    ng = mux_neg_gnd;
    chk8(data_oe_n, 1'b1);
    chk8(busy_n, !go);
    n = 0;
    while (busy_n !== 1'b1 && n < 4000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk8(busy_n, 1'b1);
  endtask : wr
  task automatic rd_chk(input int n);
    logic [7:0] v;
    for (int i = 0; i < n; i++)
    begin
      u_sas_host_model.rd(v);
      chk8(v, exp_ram[ptr_m]);
      ptr_m = (ptr_m + 1) % 8;
    end
  endtask : rd_chk
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    for (int i = 0; i < 8; i++)
      analog_input[i] = 8'($random(seed));
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk8({busy_n, data_oe_n, mux_neg_gnd, power_down}, 4'hE);
    $display("test reset done");
    for (int i = 0; i < 7; i++)
      wr(8'h10 | i, b, g);
    wr(8'h07, b, g);
    chk8({b, g}, 2'h1);
    rd_chk(8);
    wr(8'h00, b, g);
    rd_chk(8);
    $display("test multi done");
    wr(8'h15, b, g);
    rd_chk(2);
    wr(8'h83, b, g);
    rd_chk(2);
    $display("test single done");
    wr(8'h08, b, g);
    chk8(power_down, 1'b1);
    wr(8'h10, b, g);
    chk8(power_down, 1'b0);
    u_sas_host_model.wr(8'h00, 1'b0);
    chk8(busy_n, 1'b1);
    $display("test inhibit done");
    wr(8'hA1, b, g);
    chk8(b, 1'b0);
    wr(8'h81, b, g);
    chk8(b, 1'b1);
    wr(8'hC2, b, g);
    chk8(g, 1'b1);
    wr(8'h82, b, g);
    chk8(g, 1'b0);
    chk8({mux_pos, mux_neg}, 6'h13);
    rd_chk(1);
    wr(8'h50, b, g);
    wr(8'h02, b, g);
    chk8(g, 1'b0);
    rd_chk(8);
    $display("test latency done");
    mode_float = 1'b0;
    vss_neg = 1'b1;
    repeat (4) @(negedge sys_clk);
    wr(8'h90, b, g);
    chk8({b, g}, 2'h3);
    rd_chk(8);
    mode_level = 1'b1;
    vss_neg = 1'b0;
    repeat (4) @(negedge sys_clk);
    wr(8'h90, b, g);
    chk8({b, g}, 2'h0);
    chk8({mux_pos, mux_neg}, 6'h37);
    rd_chk(8);
    $display("test hard-wired done");
    give_verdict();
  end
endmodule : simultaneous_adc_sequencer_bench
